// File: mwdt_map.svh
// register map, field positions, codes and timing counts of the watchdog
`ifndef MWDT_MAP_SVH
`define MWDT_MAP_SVH

`define MWDT_ADDR_CONTROL_ONE 8'h34
`define MWDT_ADDR_CODE 8'h38
`define MWDT_ADDR_STATUS 8'h3C

`define MWDT_CTRL_RESET 8'h09
`define MWDT_BIT_OUT_SEL 0
`define MWDT_BIT_TIME_LO 1
`define MWDT_BIT_TIME_HI 2
`define MWDT_BIT_ENABLE 3

`define MWDT_CODE_CLEAR 8'h4E
`define MWDT_CODE_DISABLE 8'hB1

`define MWDT_STAT_RUNNING 0
`define MWDT_STAT_ENABLE 1
`define MWDT_STAT_OUT_SEL 2
`define MWDT_STAT_PENDING 3
`define MWDT_STAT_RESETTING 4
`define MWDT_STAT_BIN_LO 5
`define MWDT_STAT_BIN_HI 6

`define MWDT_BIN_LAST 2'h3
`define MWDT_TIME_LONGEST 2'h0
`define MWDT_TIME_SHORTEST 2'h3
`define MWDT_EXP_STEP 2
`define MWDT_BIN_STAGES 2
`define MWDT_EXP_DEFAULT 19

`define MWDT_CLK_PERIOD_PS 8000
`define MWDT_RESET_TIME_PS 192000
`define MWDT_RESET_CYCLES (`MWDT_RESET_TIME_PS / `MWDT_CLK_PERIOD_PS)

`endif

// File: mwdt_pkg.sv
// types shared by the watchdog and whoever instantiates it
`default_nettype none
package mwdt_pkg;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } mwdt_bus_req_type;

  typedef struct packed {
    logic enable;
    logic [1:0] time_sel;
    logic out_sel;
  } mwdt_ctrl_type;

  typedef enum logic [0:0] {
    MWDT_RST_IDLE = 1'b0,
    MWDT_RST_ACTIVE = 1'b1
  } mwdt_rst_state_type;

endpackage
`default_nettype wire

// File: mwdt_watchdog.sv
// watchdog timer with avalon-mm register access
`include "mwdt_map.svh"
`default_nettype none

// How it works
// [RULE1] after reset the enable bit is one and the watchdog counts at once.
// [RULE2] overflow with output select one raises the internal reset request.
// [RULE3] overflow with output select zero raises the watchdog interrupt instead.
// [RULE4] stop, warm-up and idle freeze counting; counting resumes from the held count.
// [RULE5] clear code zeroes only the two-stage binary counter, never the divider.
// [RULE6] software clears within three quarters of the detection time.
// [RULE7] time field picks 2^25, 2^23, 2^21, 2^19 periods; gear one doubles.
// [RULE8] output select, once zero, cannot be set to one again before reset.
// [RULE9] both control registers are write-only; reading them returns no state.
// [RULE10] disable code acts only while the enable bit is already zero.
// [RULE11] software disables by: interrupts off, clear code, enable zero, disable code.
// [RULE12] while disabled the binary counter is held cleared.
// [RULE13] the interrupt is non-maskable, independent of the master interrupt flag.
// [RULE14] each new overflow interrupts again even while an earlier one is served.
// [RULE15] software sets the stack pointer before choosing interrupt output.
// [RULE16] the watchdog reset request lasts at most 24 clock periods.
// [RULE17] software disables or clears before stop, and clears again after it.
// [RULE18] software never clears the counter from an interrupt task.
// [RULE19] disabling during interrupt service leaves the pending interrupt uncleared.
// [RULE20] other codes to the code register change neither counter nor enable.
module mwdt_watchdog #(
  parameter int unsigned DETECT_EXP_MIN = `MWDT_EXP_DEFAULT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire mwdt_pkg::mwdt_bus_req_type bus_req,
  output logic [31:0] bus_readdata,
  output logic bus_waitrequest,
  input wire logic low_power_hold,
  input wire logic clock_gear_select,
  input wire logic interrupt_ack,
  output logic watchdog_overflow_interrupt,
  output logic watchdog_reset_request
);
  import mwdt_pkg::*;

  localparam int unsigned DIV_W = 32;
  localparam logic [4:0] RST_LAST = 5'(`MWDT_RESET_CYCLES - 1);

  mwdt_ctrl_type watchdog_control_one;
  logic running;
  logic [DIV_W-1:0] divider;
  logic [1:0] binary_count;
  logic pending;
  mwdt_rst_state_type rst_state;
  logic [4:0] rst_count;

  logic take;
  logic wr_ctrl;
  logic wr_code;
  logic code_clear;
  logic code_disable;
  logic tick;
  logic overflow;
  logic [31:0] next_readdata;

  // exponent of the binary-counter stage period, a quarter of the detection time
  function automatic int unsigned stage_exp(input logic [1:0] sel, input logic gear);
    int unsigned e;
    e = DETECT_EXP_MIN + `MWDT_EXP_STEP * 32'(`MWDT_TIME_SHORTEST - sel);
    e = e + 32'(gear);
    if (e > `MWDT_BIN_STAGES)
      stage_exp = e - `MWDT_BIN_STAGES;
    else
      stage_exp = 1;
  endfunction

  // true when the low exp bits of the divider are all ones, i.e. it rolls over next
  function automatic logic rolls(input logic [DIV_W-1:0] d, input int unsigned exp);
    logic [DIV_W-1:0] mask;
    mask = DIV_W'((64'h1 << exp) - 64'h1);
    rolls = (d & mask) == mask;
  endfunction

  // bus decode: an access is carried out at the edge where waitrequest is low
  always_comb begin
    take = (bus_req.read || bus_req.write) && !bus_waitrequest;
    wr_ctrl = take && bus_req.write && bus_req.byteenable[0]
      && (bus_req.address == `MWDT_ADDR_CONTROL_ONE);
    wr_code = take && bus_req.write && bus_req.byteenable[0]
      && (bus_req.address == `MWDT_ADDR_CODE);
    code_clear = wr_code && (bus_req.writedata[7:0] == `MWDT_CODE_CLEAR);
    code_disable = wr_code && (bus_req.writedata[7:0] == `MWDT_CODE_DISABLE);
  end

  // one wait state: each request is answered on the second edge it is seen
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_waitrequest <= 1'b1;
    end else if (bus_waitrequest && (bus_req.read || bus_req.write)) begin
      bus_waitrequest <= 1'b0;
    end else begin
      bus_waitrequest <= 1'b1;
    end
  end

  // control registers read as zero so no watchdog state leaks through them
  always_comb begin
    next_readdata = 32'h0;
    if (bus_req.address == `MWDT_ADDR_STATUS) begin // RULE9
      next_readdata[`MWDT_STAT_RUNNING] = running;
      next_readdata[`MWDT_STAT_ENABLE] = watchdog_control_one.enable;
      next_readdata[`MWDT_STAT_OUT_SEL] = watchdog_control_one.out_sel;
      next_readdata[`MWDT_STAT_PENDING] = pending;
      next_readdata[`MWDT_STAT_RESETTING] = (rst_state == MWDT_RST_ACTIVE);
      next_readdata[`MWDT_STAT_BIN_HI:`MWDT_STAT_BIN_LO] = binary_count;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_readdata <= 32'h0;
    end else if (bus_waitrequest && bus_req.read) begin
      bus_readdata <= next_readdata;
    end
  end

  // control register one; output select may only move from one to zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_control_one <= mwdt_ctrl_type'(`MWDT_CTRL_RESET); // RULE1
    end else if (wr_ctrl) begin
      watchdog_control_one.enable <= bus_req.writedata[`MWDT_BIT_ENABLE];
      watchdog_control_one.time_sel <=
        bus_req.writedata[`MWDT_BIT_TIME_HI:`MWDT_BIT_TIME_LO];
      watchdog_control_one.out_sel <= watchdog_control_one.out_sel
        & bus_req.writedata[`MWDT_BIT_OUT_SEL]; // RULE8
    end
  end

  // running follows the enable bit up at once, but goes down only on the disable code
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      running <= 1'b1; // RULE1
    end else if (wr_ctrl && bus_req.writedata[`MWDT_BIT_ENABLE]) begin
      running <= 1'b1;
    end else if (code_disable && !watchdog_control_one.enable) begin
      running <= 1'b0; // RULE10 RULE20
    end
  end

  // free-running prescaler; a clear code leaves it alone, hence the 3/4 minimum
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      divider <= '0;
    end else if (!low_power_hold) begin // RULE4
      divider <= divider + DIV_W'(1); // RULE5
    end
  end

  always_comb begin
    tick = running && !low_power_hold // RULE4
      && rolls(divider, stage_exp(watchdog_control_one.time_sel, clock_gear_select)); // RULE7
    overflow = tick && (binary_count == `MWDT_BIN_LAST);
  end

  // two-stage binary counter; overflow on the fourth tick, 3 to 4 stage periods after a clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      binary_count <= 2'h0;
    end else if (!running || code_clear) begin
      binary_count <= 2'h0; // RULE5 RULE12
    end else if (rst_state == MWDT_RST_ACTIVE) begin
      binary_count <= 2'h0;
    end else if (tick) begin
      binary_count <= binary_count + 2'h1;
    end
  end

  // interrupt pulse is not gated by any mask: every overflow with output select zero fires it again
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_overflow_interrupt <= 1'b0;
    end else begin
      watchdog_overflow_interrupt <= overflow && !watchdog_control_one.out_sel; // RULE3 RULE13 RULE14
    end
  end

  // pending survives a disable; only the acknowledge clears it, and a new overflow wins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending <= 1'b0;
    end else if (overflow && !watchdog_control_one.out_sel) begin
      pending <= 1'b1; // RULE14
    end else if (interrupt_ack) begin
      pending <= 1'b0; // RULE19
    end
  end

  // reset request: fixed-length pulse, bounded by the documented maximum
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_state <= MWDT_RST_IDLE;
      rst_count <= 5'h0;
    end else begin
      case (rst_state)
        MWDT_RST_IDLE: begin
          rst_count <= 5'h0;
          if (overflow && watchdog_control_one.out_sel) begin
            rst_state <= MWDT_RST_ACTIVE; // RULE2
          end
        end
        MWDT_RST_ACTIVE: begin
          if (rst_count == RST_LAST) begin
            rst_state <= MWDT_RST_IDLE; // RULE16
            rst_count <= 5'h0;
          end else begin
            rst_count <= rst_count + 5'h1;
          end
        end
        default: begin
          rst_state <= MWDT_RST_IDLE;
          rst_count <= 5'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      watchdog_reset_request <= 1'b0;
    end else begin
      watchdog_reset_request <= (rst_state == MWDT_RST_ACTIVE); // RULE2 RULE16
    end
  end

endmodule // mwdt_watchdog
`default_nettype wire

// File: mwdt_props.sv
// assertion checker for the watchdog ports
`include "mwdt_map.svh"
`default_nettype none
module mwdt_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire mwdt_pkg::mwdt_bus_req_type bus_req,
  input wire logic [31:0] bus_readdata,
  input wire logic bus_waitrequest,
  input wire logic low_power_hold,
  input wire logic watchdog_overflow_interrupt,
  input wire logic watchdog_reset_request
);
  import mwdt_pkg::*;
  logic [4:0] hi_cnt;
  wire logic clr_ok = bus_req.write && !bus_waitrequest &&
    bus_req.address == `MWDT_ADDR_CODE && bus_req.writedata[7:0] == `MWDT_CODE_CLEAR;
  // counts high cycles of the reset request; too long a pulse must not wrap silently
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst) hi_cnt <= 5'h00;
    else hi_cnt <= watchdog_reset_request ? hi_cnt + 5'h01 : 5'h00;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_req_max; watchdog_reset_request |-> hi_cnt < 5'h18; endproperty
  a_req_max: assert property (p_req_max) else $error("reset request too long");
  property p_req_len; $fell(watchdog_reset_request) |-> hi_cnt == 5'h18; endproperty
  a_req_len: assert property (p_req_len) else $error("reset request length wrong");
  property p_irq_pulse; watchdog_overflow_interrupt |=> !watchdog_overflow_interrupt; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not a pulse");
  property p_excl; !(watchdog_overflow_interrupt && watchdog_reset_request); endproperty
  a_excl: assert property (p_excl) else $error("interrupt and reset together");
  // four cycles of margin so the registered outputs, up to two cycles behind an overflow, do not trip it
  property p_hold; low_power_hold[*4] |->
    !watchdog_overflow_interrupt && !$rose(watchdog_reset_request); endproperty
  a_hold: assert property (p_hold) else $error("overflow while held");
  property p_clear; clr_ok |=> ##1
    (!watchdog_overflow_interrupt && !$rose(watchdog_reset_request))[*8]; endproperty
  a_clear: assert property (p_clear) else $error("overflow right after clear");
  property p_wait; (bus_req.read || bus_req.write) && bus_waitrequest |=> !bus_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer late");
  property p_wo_read; bus_req.read && !bus_waitrequest &&
    bus_req.address != `MWDT_ADDR_STATUS |-> bus_readdata == 32'h0; endproperty
  a_wo_read: assert property (p_wo_read) else $error("write-only read not zero");
endmodule // mwdt_props
bind mwdt_watchdog mwdt_props u_props (
  .clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_readdata(bus_readdata),
  .bus_waitrequest(bus_waitrequest), .low_power_hold(low_power_hold),
  .watchdog_overflow_interrupt(watchdog_overflow_interrupt),
  .watchdog_reset_request(watchdog_reset_request));
`default_nettype wire

// File: test_mcu_watchdog_timer.sv
// self-checking bench for the watchdog
`include "mwdt_map.svh"
`default_nettype none
module test_mcu_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import mwdt_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  mwdt_bus_req_type req = 46'h1; // byteenable lane 0 always on
  logic hold = 1'b0;
  logic gear = 1'b0;
  logic ack = 1'b0;
  logic [31:0] rdata, got;
  logic wait_req, irq, wreq;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int last_req = 0;
  int n, p;
  always #4 clk = ~clk;
  mwdt_watchdog #(.DETECT_EXP_MIN(4)) u_dut (.clk(clk), .sys_rst(sys_rst), .bus_req(req),
    .bus_readdata(rdata), .bus_waitrequest(wait_req), .low_power_hold(hold),
    .clock_gear_select(gear), .interrupt_ack(ack), .watchdog_overflow_interrupt(irq),
    .watchdog_reset_request(wreq));
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wreq === 1'b1) last_req <= cyc;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic acc(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req.read <= rd;
    req.write <= !rd;
    req.address <= a;
    req.writedata <= {24'h0, d};
    @(posedge clk);
    while (wait_req !== 1'b0) @(posedge clk);
    got = rdata;
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask
  // counts edges until the chosen output is seen high, giving up at lim
  task automatic upto(input logic use_irq, input int lim);
    n = 0;
    while (n < lim && (use_irq ? irq : wreq) !== 1'b1) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  initial begin
    do_reset();
    acc(1'b1, `MWDT_ADDR_STATUS, 8'h00);
    chk(got & 32'h1F, 32'h07);
    for (int a = 52; a <= 68; a += (a == 56) ? 8 : 4) begin
      acc(1'b1, 8'(a), 8'h00);
      chk(got, 32'h0);
    end
    upto(1'b0, 1100);
    chk(n > 700 && n < 1100, 1);
    n = 0;
    while (wreq === 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    chk(n, 24);
    $display("test reset defaults done");
    // the divider is never cleared, so only a window of 3 to 4 stage periods holds
    for (int t = 0; t < 5; t++) begin
      gear <= (t == 4);
      acc(1'b0, `MWDT_ADDR_CONTROL_ONE, {4'h0, 1'b1, 2'(t), 1'b1});
      acc(1'b0, `MWDT_ADDR_CODE, `MWDT_CODE_CLEAR);
      p = 1 << (8 - 2 * (t % 4) + (t == 4));
      upto(1'b0, 5 * p);
      chk(n >= 3 * p && n <= 4 * p + 2, 1);
      repeat (26) @(posedge clk);
    end
    $display("test detection times done");
    gear <= 1'b0;
    acc(1'b0, `MWDT_ADDR_CONTROL_ONE, 8'h0F);
    p = cyc;
    repeat (30) acc(1'b0, `MWDT_ADDR_CODE, `MWDT_CODE_CLEAR);
    chk(last_req < p, 1);
    hold <= 1'b1;
    upto(1'b0, 100);
    chk(n, 100);
    hold <= 1'b0;
    upto(1'b0, 30);
    chk(n > 0 && n <= 18, 1);
    repeat (26) @(posedge clk);
    $display("test clear and hold done");
    do_reset();
    acc(1'b0, `MWDT_ADDR_CONTROL_ONE, 8'h0E);
    acc(1'b0, `MWDT_ADDR_CODE, `MWDT_CODE_CLEAR);
    upto(1'b1, 40);
    chk(n >= 12 && n <= 18, 1);
    acc(1'b0, `MWDT_ADDR_CONTROL_ONE, 8'h0F);
    upto(1'b0, 40);
    chk(n, 40);
    acc(1'b1, `MWDT_ADDR_STATUS, 8'h00);
    chk(got[3:2], 2'b10);
    // the service routine only acknowledges; clears come from the main flow
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    acc(1'b0, `MWDT_ADDR_CODE, `MWDT_CODE_DISABLE);
    upto(1'b1, 40);
    chk(n < 40, 1);
    acc(1'b0, `MWDT_ADDR_CODE, `MWDT_CODE_CLEAR);
    acc(1'b0, `MWDT_ADDR_CONTROL_ONE, 8'h06);
    acc(1'b0, `MWDT_ADDR_CODE, 8'h20);
    upto(1'b1, 40);
    chk(n < 40, 1);
    acc(1'b0, `MWDT_ADDR_CODE, `MWDT_CODE_CLEAR);
    acc(1'b0, `MWDT_ADDR_CODE, `MWDT_CODE_DISABLE);
    upto(1'b1, 200);
    chk(n, 200);
    acc(1'b1, `MWDT_ADDR_STATUS, 8'h00);
    chk(got & 32'h69, 32'h08);
    $display("test interrupt and disable done");
    complete_run();
  end
endmodule // test_mcu_watchdog_timer
`default_nettype wire
